// ===== rtl/period_timer.sv
/*
 * Period timer: prescaler, 8-bit counter with period register,
 * 4-bit postscaler, sticky match flag with mask and interrupt output.
 * Assumes the register master keeps strobes one cycle long and never
 * raises read and write together; instruction-cycle tick comes in.
 */
// Functional notes
// RULE_01 - Count up, wrap to zero after period match
// RULE_02 - Counter readable, writable, reset to zero
// RULE_03 - Instruction tick prescaled by 1, 4, 16
// RULE_04 - Period register read/write, resets all ones
// RULE_05 - Postscaled matches set interrupt flag bit one
// RULE_06 - Postscale ratio is field value plus one
// RULE_07 - Run bit clear stops counting
// RULE_08 - Counter/control write or reset clears scalers
// RULE_09 - Control write keeps counter value
// RULE_10 - Raw match offered to serial port
// RULE_11 - Raw match offered to PWM time base
module period_timer (
    input wire logic mclk,
    input wire logic srst,
    input wire logic inst_tick,
    input wire period_timer_pkg::reg_req_t req,
    output logic [7:0] rdata,
    output logic irq,
    output logic serial_shift_tick,
    output logic pwm_period_tick
);
    logic [7:0] control_r;
    logic [7:0] counter_r;
    logic [7:0] period_r;
    logic [7:0] status_r;
    logic [7:0] mask_r;
    logic [3:0] presc_r;
    logic [3:0] posts_r;
    logic wr_counter;
    logic wr_control;
    logic wr_period;
    logic wr_status;
    logic wr_mask;
    logic [1:0] presc_sel;
    logic [3:0] posts_sel;
    logic timer_run;
    logic [3:0] presc_top;
    logic count_tick;
    logic match;
    logic post_fire;
    logic match_r;

    // Address decode of write strobes
    assign wr_counter = req.wr && req.addr == period_timer_pkg::tick_counter_off;
    assign wr_control = req.wr && req.addr == period_timer_pkg::timer_control_off;
    assign wr_period = req.wr && req.addr == period_timer_pkg::period_limit_off;
    assign wr_status = req.wr && req.addr == period_timer_pkg::irq_status_off;
    assign wr_mask = req.wr && req.addr == period_timer_pkg::irq_mask_off;

    // Control fields
    assign presc_sel = control_r[period_timer_pkg::presc_lsb +: 2];
    assign posts_sel = control_r[period_timer_pkg::posts_lsb +: 4];
    assign timer_run = control_r[period_timer_pkg::run_bit];

    // Prescaler terminal count from select
    always_comb begin
        case (presc_sel)
            period_timer_pkg::presc_div1: presc_top = period_timer_pkg::presc_top1; // RULE_03
            period_timer_pkg::presc_div4: presc_top = period_timer_pkg::presc_top4;
            default: presc_top = period_timer_pkg::presc_top16;
        endcase
    end

    // Counter advances once per prescaled tick while running
    assign count_tick = timer_run && inst_tick && presc_r == presc_top; // RULE_07
    assign match = count_tick && counter_r == period_r; // RULE_01
    assign post_fire = match && posts_r == posts_sel; // RULE_06

    // Control register
    always_ff @(posedge mclk) begin
        if (srst) begin
            control_r <= period_timer_pkg::control_rst;
        end else if (wr_control) begin
            control_r <= req.wdata & period_timer_pkg::control_wmask;
        end
    end

    // Period register
    always_ff @(posedge mclk) begin
        if (srst) begin
            period_r <= period_timer_pkg::period_rst; // RULE_04
        end else if (wr_period) begin
            period_r <= req.wdata; // RULE_04
        end
    end

    // Prescaler, cleared by counter or control write
    always_ff @(posedge mclk) begin
        if (srst || wr_counter || wr_control) begin
            presc_r <= 4'h0; // RULE_08
        end else if (timer_run && inst_tick) begin
            if (presc_r == presc_top) begin
                presc_r <= 4'h0;
            end else begin
                presc_r <= presc_r + 4'h1; // RULE_03
            end
        end
    end

    // Counter; control writes leave it alone
    always_ff @(posedge mclk) begin
        if (srst) begin
            counter_r <= period_timer_pkg::counter_rst; // RULE_02
        end else if (wr_counter) begin
            counter_r <= req.wdata; // RULE_02
        end else if (match) begin
            counter_r <= 8'h00; // RULE_01
        end else if (count_tick) begin
            counter_r <= counter_r + 8'h01; // RULE_09
        end
    end

    // Postscaler counts matches
    always_ff @(posedge mclk) begin
        if (srst || wr_counter || wr_control) begin
            posts_r <= 4'h0; // RULE_08
        end else if (match) begin
            if (post_fire) begin
                posts_r <= 4'h0;
            end else begin
                posts_r <= posts_r + 4'h1; // RULE_05
            end
        end
    end

    // Sticky flag; set wins over write-one-to-clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            status_r <= period_timer_pkg::status_rst;
        end else begin
            status_r[period_timer_pkg::match_flag_bit] <=
                post_fire || (status_r[period_timer_pkg::match_flag_bit] &&
                !(wr_status &&
                req.wdata[period_timer_pkg::match_flag_bit])); // RULE_05
        end
    end

    // Interrupt mask
    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_r <= period_timer_pkg::mask_rst;
        end else if (wr_mask) begin
            mask_r <= req.wdata & period_timer_pkg::status_wmask;
        end
    end

    // Registered match pulse for serial port and PWM
    always_ff @(posedge mclk) begin
        if (srst) begin
            match_r <= 1'b0;
        end else begin
            match_r <= match;
        end
    end
    assign serial_shift_tick = match_r; // RULE_10
    assign pwm_period_tick = match_r; // RULE_11
    assign irq = |(status_r & mask_r);

    // Read data, one cycle after the strobe, zero otherwise
    always_ff @(posedge mclk) begin
        if (srst || !req.rd) begin
            rdata <= 8'h00;
        end else begin
            case (req.addr)
                period_timer_pkg::tick_counter_off: rdata <= counter_r; // RULE_02
                period_timer_pkg::timer_control_off: rdata <= control_r;
                period_timer_pkg::period_limit_off: rdata <= period_r;
                period_timer_pkg::irq_status_off: rdata <= status_r;
                period_timer_pkg::irq_mask_off: rdata <= mask_r;
                default: rdata <= 8'h00;
            endcase
        end
    end

    // Flag bit view used by the checks below
    logic period_match_flag;
    assign period_match_flag = status_r[period_timer_pkg::match_flag_bit];

    // Steps of a postscaled match: fire, then flag up
    sequence s_post_fire;
        post_fire;
    endsequence
    sequence s_flag_up;
        period_match_flag;
    endsequence

    // Steps of a raw match: hit, then both ticks out
    sequence s_raw_match;
        match;
    endsequence
    sequence s_ticks_out;
        serial_shift_tick && pwm_period_tick;
    endsequence

    // Match returns the counter to zero
    a_match_wrap: assert property (@(posedge mclk) // RULE_01
        disable iff (srst) match && !req.wr |=> counter_r == 8'h00)
        else $error("counter did not wrap after match");

    // Plain advance adds one
    a_count_step: assert property (@(posedge mclk) // RULE_01
        disable iff (srst) count_tick && !match && !req.wr |=>
        counter_r == $past(counter_r) + 8'h01)
        else $error("counter did not step by one");

    // No advance and no write keeps the counter
    a_count_idle: assert property (@(posedge mclk) // RULE_01
        disable iff (srst) !count_tick && !wr_counter |=> $stable(counter_r))
        else $error("counter moved without a tick");

    // Reset values of counter and period
    a_counter_rst: assert property (@(posedge mclk) // RULE_02
        srst |=> counter_r == 8'h00 && period_r == 8'hff)
        else $error("reset values wrong");

    // Software write lands in the counter
    a_count_write: assert property (@(posedge mclk) // RULE_02
        disable iff (srst) wr_counter |=> counter_r == $past(req.wdata))
        else $error("counter write lost");

    // Counter read returns the value of the strobe cycle
    a_read_count: assert property (@(posedge mclk) // RULE_02
        disable iff (srst)
        req.rd && req.addr == period_timer_pkg::tick_counter_off |=>
        rdata == $past(counter_r))
        else $error("counter read wrong");

    // Read data rest at zero outside the answer cycle
    a_rdata_idle: assert property (@(posedge mclk) // RULE_02
        disable iff (srst) !req.rd |=> rdata == 8'h00)
        else $error("read data not zero when idle");

    // Divide by four reaches its terminal from two
    a_presc_div4: assert property (@(posedge mclk) // RULE_03
        disable iff (srst)
        count_tick && presc_sel == period_timer_pkg::presc_div4 |->
        $past(presc_r) == 4'h2)
        else $error("divide by four wrong");

    // Divide by one advances on every tick
    a_presc_div1: assert property (@(posedge mclk) // RULE_03
        disable iff (srst)
        count_tick && presc_sel == period_timer_pkg::presc_div1 |->
        presc_r == 4'h0)
        else $error("divide by one wrong");

    // Divide by sixteen advances at terminal fifteen
    a_presc_div16: assert property (@(posedge mclk) // RULE_03
        disable iff (srst) count_tick && presc_sel[1] |->
        presc_r == period_timer_pkg::presc_top16)
        else $error("divide by sixteen wrong");

    // Prescaler never passes its terminal count
    a_presc_range: assert property (@(posedge mclk) // RULE_03
        disable iff (srst) presc_r <= presc_top)
        else $error("prescaler out of range");

    // Control write stores the writable bits
    a_ctrl_write: assert property (@(posedge mclk) // RULE_03
        disable iff (srst) wr_control |=>
        control_r == ($past(req.wdata) & period_timer_pkg::control_wmask))
        else $error("control write lost");

    // Period reset value
    a_period_rst: assert property (@(posedge mclk) // RULE_04
        srst |=> period_r == period_timer_pkg::period_rst)
        else $error("period not all ones after reset");

    // Period write lands
    a_per_write: assert property (@(posedge mclk) // RULE_04
        disable iff (srst) wr_period |=> period_r == $past(req.wdata))
        else $error("period write lost");

    // Period holds without a write
    a_per_hold: assert property (@(posedge mclk) // RULE_04
        disable iff (srst) !wr_period |=> $stable(period_r))
        else $error("period changed without a write");

    // Period read returns the stored value
    a_read_per: assert property (@(posedge mclk) // RULE_04
        disable iff (srst)
        req.rd && req.addr == period_timer_pkg::period_limit_off |=>
        rdata == $past(period_r))
        else $error("period read wrong");

    // Postscaler fire raises the sticky flag
    a_flag_set: assert property (@(posedge mclk) // RULE_05
        disable iff (srst) s_post_fire |=> s_flag_up)
        else $error("flag not set by postscaler");

    // Flag stays until written with a one
    a_flag_hold: assert property (@(posedge mclk) // RULE_05
        disable iff (srst) period_match_flag &&
        !(wr_status && req.wdata[period_timer_pkg::match_flag_bit]) |=>
        period_match_flag)
        else $error("flag dropped by itself");

    // Write one clears the flag when no fire meets it
    a_flag_clear: assert property (@(posedge mclk) // RULE_05
        disable iff (srst) wr_status &&
        req.wdata[period_timer_pkg::match_flag_bit] && !post_fire |=>
        !period_match_flag)
        else $error("flag not cleared");

    // Only the postscaler sets the flag
    a_flag_source: assert property (@(posedge mclk) // RULE_05
        disable iff (srst) !period_match_flag && !post_fire |=>
        !period_match_flag)
        else $error("flag set without a fire");

    // Interrupt follows flag and mask
    a_irq_level: assert property (@(posedge mclk) // RULE_05
        disable iff (srst)
        irq == (period_match_flag &&
        mask_r[period_timer_pkg::match_flag_bit]))
        else $error("interrupt level wrong");

    // Status and mask hold no other bits
    a_unused_bits: assert property (@(posedge mclk) // RULE_05
        disable iff (srst)
        (status_r & ~period_timer_pkg::status_wmask) == 8'h00 &&
        (mask_r & ~period_timer_pkg::status_wmask) == 8'h00)
        else $error("unused status or mask bit set");

    // Postscaler steps once per unfired match
    a_posts_step: assert property (@(posedge mclk) // RULE_05
        disable iff (srst) match && !post_fire && !req.wr |=>
        posts_r == $past(posts_r) + 4'h1)
        else $error("postscaler did not step");

    // Postscaler holds between matches
    a_posts_hold: assert property (@(posedge mclk) // RULE_05
        disable iff (srst) !match && !req.wr |=> $stable(posts_r))
        else $error("postscaler moved without a match");

    // Fire comes on match number select plus one
    a_post_ratio: assert property (@(posedge mclk) // RULE_06
        disable iff (srst) post_fire |-> posts_r == posts_sel)
        else $error("postscale ratio wrong");

    // Postscaler never passes its select
    a_posts_range: assert property (@(posedge mclk) // RULE_06
        disable iff (srst) posts_r <= posts_sel)
        else $error("postscaler out of range");

    // Fire restarts the postscaler
    a_posts_wrap: assert property (@(posedge mclk) // RULE_06
        disable iff (srst) post_fire |=> posts_r == 4'h0)
        else $error("postscaler did not restart");

    // Stopped timer keeps its count
    a_stop_hold: assert property (@(posedge mclk) // RULE_07
        disable iff (srst) !timer_run && !req.wr |=> $stable(counter_r))
        else $error("counter moved while stopped");

    // Stopped timer keeps both scalers at zero
    a_stop_scalers: assert property (@(posedge mclk) // RULE_07
        disable iff (srst) !timer_run |-> presc_r == 4'h0 && posts_r == 4'h0)
        else $error("scalers running while stopped");

    // Counter or control write clears both scalers
    a_scaler_clr: assert property (@(posedge mclk) // RULE_08
        disable iff (srst)
        wr_control || wr_counter |=> presc_r == 4'h0 && posts_r == 4'h0)
        else $error("scalers not cleared");

    // Control write never loads or clears the counter
    a_ctrl_keep: assert property (@(posedge mclk) // RULE_09
        disable iff (srst) wr_control && !match |=>
        counter_r == $past(counter_r) + 8'($past(count_tick)))
        else $error("control write changed counter");

    // Raw match is offered one cycle later
    a_match_out: assert property (@(posedge mclk) // RULE_10
        disable iff (srst) s_raw_match |=> s_ticks_out)
        else $error("match not offered");

    // Serial tick only follows a raw match
    a_tick_source: assert property (@(posedge mclk) // RULE_10
        disable iff (srst) serial_shift_tick |-> $past(match))
        else $error("serial tick without a match");

    // Time base output equals the serial tick
    a_pwm_same: assert property (@(posedge mclk) // RULE_11
        disable iff (srst) pwm_period_tick == serial_shift_tick)
        else $error("time base differs from serial tick");
endmodule

// ===== common/period_timer_pkg.sv
/*
 * Package for the 8-bit period timer: register offsets, field positions,
 * reset values, the register-port struct and the prescale codes.
 * Assumes a byte-wide register port and one clock domain.
 */
package period_timer_pkg;
    // Register offsets on the plain register port
    localparam logic [7:0] tick_counter_off = 8'h11;
    localparam logic [7:0] timer_control_off = 8'h12;
    localparam logic [7:0] period_limit_off = 8'h92;
    localparam logic [7:0] irq_status_off = 8'h0c;
    localparam logic [7:0] irq_mask_off = 8'h8c;
    // Control field positions
    localparam int presc_lsb = 0;
    localparam int run_bit = 2;
    localparam int posts_lsb = 3;
    // Status and mask bit position of the period match flag
    localparam int match_flag_bit = 1;
    // Writable bits of the control register and of status and mask
    localparam logic [7:0] control_wmask = 8'h7f;
    localparam logic [7:0] status_wmask = 8'h02;
    // Reset values
    localparam logic [7:0] control_rst = 8'h00;
    localparam logic [7:0] counter_rst = 8'h00;
    localparam logic [7:0] period_rst = 8'hff;
    localparam logic [7:0] status_rst = 8'h00;
    localparam logic [7:0] mask_rst = 8'h00;
    // Prescale codes
    localparam logic [1:0] presc_div1 = 2'h0;
    localparam logic [1:0] presc_div4 = 2'h1;
    // Prescaler terminal counts
    localparam logic [3:0] presc_top1 = 4'h0;
    localparam logic [3:0] presc_top4 = 4'h3;
    localparam logic [3:0] presc_top16 = 4'hf;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

// ===== tb/period_timer_test.sv
/*
 * Self-checking bench for the period timer: register table, prescale,
 * postscale, interrupt masking, run bit and reset checks.
 * Assumes the timer package and module are compiled before this file.
 */
module period_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic inst_tick = 1'b1;
    period_timer_pkg::reg_req_t req = '0;
    logic [7:0] rdata;
    logic irq;
    logic serial_shift_tick;
    logic pwm_period_tick;
    int errors = 0;
    int n_checks = 0;
    int cnt = 0;
    int n;
    logic [7:0] d;
    logic [7:0] e;
    // Rows: address, value written, reset value, value read back
    logic [7:0] rows [6][4] = '{'{8'h11, 8'h5a, 8'h00, 8'h5a},
        '{8'h92, 8'h3c, 8'hff, 8'h3c}, '{8'h8c, 8'hff, 8'h00, 8'h02},
        '{8'h0c, 8'hff, 8'h00, 8'h00}, '{8'h13, 8'hff, 8'h00, 8'h00},
        '{8'h12, 8'hff, 8'h00, 8'h7f}};
    int divs [4] = '{1, 4, 16, 16};
    int posts [3] = '{0, 2, 15};

    period_timer period_timer_inst (
        .mclk(mclk),
        .srst(srst),
        .inst_tick(inst_tick),
        .req(req),
        .rdata(rdata),
        .irq(irq),
        .serial_shift_tick(serial_shift_tick),
        .pwm_period_tick(pwm_period_tick)
    );

    // 200 MHz clock
    always #2.5 mclk = ~mclk;

    // Counts raw match ticks
    always @(posedge mclk) if (serial_shift_tick === 1'b1) cnt <= cnt + 1;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req <= '0;
        #1 v = rdata;
    endtask

    // Bounded wait for the interrupt or a raw tick; c gets the cycles
    task automatic wait_for(input bit on_irq, output int c);
        c = 0;
        do begin
            @(posedge mclk);
            #1 c++;
            if (c > 2000) begin
                errors++;
                results();
            end
        end while (!(on_irq ? irq === 1'b1 : serial_shift_tick === 1'b1));
    endtask

    task automatic do_reset();
        @(posedge mclk);
        srst <= 1'b1;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
    endtask

    initial begin
        do_reset();
        // Reset values, write and read-back of every place
        foreach (rows[i]) begin
            rd(rows[i][0], d);
            chk(d, rows[i][2]);
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0], d);
            chk(d, rows[i][3]);
        end
        // Second reset in mid-run with the timer going
        do_reset();
        rd(8'h11, d);
        chk(d, 8'h00);
        rd(8'h92, d);
        chk(d, 8'hff);
        // Tick spacing for every prescale code, period 3
        wr(8'h92, 8'h03);
        foreach (divs[i]) begin
            wr(8'h12, 8'h04 | 8'(i));
            wait_for(1'b0, n);
            wait_for(1'b0, n);
            chk(8'(n), 8'(4 * divs[i]));
            chk(pwm_period_tick, 1'b1);
        end
        // Postscaler: raw ticks between flag sets
        wr(8'h92, 8'h07);
        wr(8'h8c, 8'h02);
        foreach (posts[i]) begin
            wr(8'h12, {1'b0, 4'(posts[i]), 3'h4});
            wr(8'h0c, 8'h02);
            wait_for(1'b1, n);
            wr(8'h0c, 8'h02);
            #1 cnt = 0;
            wait_for(1'b1, n);
            @(posedge mclk);
            #1 chk(8'(cnt), 8'(posts[i] + 1));
        end
        // Masking and write-one-to-clear of the sticky flag
        wr(8'h8c, 8'h00);
        #1 chk(irq, 1'b0);
        rd(8'h0c, d);
        chk(d, 8'h02);
        wr(8'h8c, 8'h02);
        #1 chk(irq, 1'b1);
        wr(8'h0c, 8'h02);
        #1 chk(irq, 1'b0);
        // Control write keeps the counter, counter write loads it
        wr(8'h12, 8'h06);
        wr(8'h11, 8'h20);
        wr(8'h12, 8'h06);
        rd(8'h11, d);
        chk(d, 8'h20);
        // Run bit cleared freezes the count
        wr(8'h12, 8'h02);
        rd(8'h11, e);
        repeat (40) @(posedge mclk);
        rd(8'h11, d);
        chk(d, e);
        results();
    end
endmodule
